// ### design/pump_framer_pkg.sv
`default_nettype none
package pump_framer_pkg;
  // ==========================================================
  // Serial timing
  localparam int CLK_HZ   = 20_000_000;
  localparam int BAUD     = 19200;
  localparam int BIT_CYC  = CLK_HZ / BAUD;
  localparam int HALF_CYC = BIT_CYC / 2;
  localparam int FRAME_BITS = 10;
  localparam int DATA_BITS  = 8;
  localparam int FIFO_DEPTH = 16;
  // ==========================================================
  // Characters
  localparam logic [7:0] CH_STX  = 8'h02;
  localparam logic [7:0] CH_ETX  = 8'h03;
  localparam logic [7:0] CH_CR   = 8'h0d;
  localparam logic [7:0] CH_SP   = 8'h20;
  localparam logic [7:0] CH_DEL  = 8'h7f;
  localparam logic [7:0] CH_0    = 8'h30;
  localparam logic [7:0] CH_9    = 8'h39;
  localparam logic [7:0] CH_PT   = 8'h2e;
  localparam logic [7:0] CH_LA   = 8'h61;
  localparam logic [7:0] CH_LZ   = 8'h7a;
  localparam logic [7:0] CASE_M  = 8'hdf;
  localparam logic [31:0] KW_ADDR  = 32'h2a414452;
  localparam logic [23:0] KW_PROTO = 24'h534146;
  // ==========================================================
  // Address, limits, framing
  localparam logic [6:0] ADDR_DEFAULT = 7'h00;
  localparam logic [6:0] ADDR_MAX     = 7'h63;
  localparam logic [6:0] PHASE_MAX    = 7'h29;
  localparam logic [6:0] TEN          = 7'h0a;
  localparam logic [7:0] SAFE_OVH     = 8'h04;
  localparam logic [2:0] BODY_KW      = 3'h3;
  localparam logic [2:0] BODY_MAX     = 3'h4;
  localparam logic [2:0] FLT_DIG_MAX  = 3'h4;
  localparam logic [2:0] FLT_FRAC_MAX = 3'h3;
  localparam logic [15:0] CRC_POLY    = 16'h1021;
  localparam logic [15:0] CRC_INIT    = 16'h0000;
  localparam int RSP_MAX = 5;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    CMD_OTHER = 3'b001,
    CMD_ADDR  = 3'b010,
    CMD_PROTO = 3'b100
  } cmd_kind_t;
  typedef struct packed {
    cmd_kind_t   kind;
    logic        has_arg;
    logic [6:0]  arg;
    logic [31:0] text;
    logic        phase_ok;
    logic        count_ok;
    logic        float_ok;
  } cmd_t;
  typedef struct packed {
    logic       safe;
    logic [6:0] addr;
  } nv_t;
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction
endpackage
`default_nettype wire

// ### design/sync_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module sync_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys_in,  // System clock
  input  wire logic             rst_n_in,    // Async reset
  input  wire logic             in_valid_in, // Write request
  output logic                  in_ready_out,// Not full
  input  wire logic [WIDTH-1:0] in_data_in,  // Write data
  output logic                  out_valid_out,// Not empty
  input  wire logic             out_ready_in,// Read accept
  output logic      [WIDTH-1:0] out_data_out // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             wr;
  logic             rd;
  assign in_ready_out  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_r != '0);
  assign wr = in_valid_in && in_ready_out;
  assign rd = out_valid_out && out_ready_in;
  assign out_data_out = mem_r[rp_r];
  always_ff @(posedge clk_sys_in) begin
    if (wr) begin
      mem_r[wp_r] <= in_data_in;
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (wr) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (rd) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end
endmodule // sync_fifo
`default_nettype wire

// ### design/pump_serial_command_framer.sv
`timescale 1ns/10ps
`default_nettype none
module pump_serial_command_framer
  import pump_framer_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYC
) (
  input  wire logic       clk_sys_in,     // 20 MHz clock
  input  wire logic       rst_n_in,       // Async reset, low
  input  wire logic       rx_pin_in,      // Serial in
  output logic            tx_pin_out,     // Serial out
  input  wire nv_t        nv_in,          // Stored settings
  output nv_t             nv_out,         // Settings to store
  output logic            nv_write_out,   // Store pulse
  input  wire logic [7:0] status_char_in, // Pump state char
  input  wire logic       alarm_in,       // Alarm event pulse
  output logic            cmd_valid_out,  // Command pulse
  output cmd_t            cmd_out,        // Command fields
  input  wire logic       proc_done_in,   // Command processed
  output logic            busy_out        // Input held off
);
  localparam int CW = $clog2(BIT_CYCLES + 1);
  localparam logic [CW-1:0] BIT_LAST  = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] HALF_LAST = CW'(BIT_CYCLES / 2);
  // ==========================================================
  // Receiver
  logic          rx_s1_r, rx_s2_r, rx_act_r, rx_done_r, rx_err_r;
  logic [CW-1:0] rx_cnt_r;
  logic [3:0]    rx_bit_r;
  logic [7:0]    rx_sh_r;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end else begin
      rx_s1_r <= rx_pin_in;
      rx_s2_r <= rx_s1_r;
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_act_r <= 1'b0; rx_cnt_r <= '0; rx_bit_r <= '0;
      rx_sh_r <= '0; rx_done_r <= 1'b0; rx_err_r <= 1'b0;
    end else begin
      rx_done_r <= 1'b0;
      if (!rx_act_r) begin
        if (!rx_s2_r) begin
          rx_act_r <= 1'b1;
          rx_cnt_r <= HALF_LAST;
          rx_bit_r <= '0;
        end
      end else if (rx_cnt_r != '0) begin
        rx_cnt_r <= rx_cnt_r - 1'b1;
      end else begin
        rx_cnt_r <= BIT_LAST;
        rx_bit_r <= rx_bit_r + 1'b1;
        if (rx_bit_r == 4'h0 && rx_s2_r) begin
          rx_act_r <= 1'b0;
        end else if (rx_bit_r <= 4'(DATA_BITS)) begin
          if (rx_bit_r != 4'h0) rx_sh_r <= {rx_s2_r, rx_sh_r[7:1]};
        end else begin
          rx_act_r  <= 1'b0;
          rx_done_r <= 1'b1;
          rx_err_r  <= !rx_s2_r;
        end
      end
    end
  end
  // ==========================================================
  // Byte FIFO; full or busy drops the byte at the pin side
  logic       busy_r, f_in_ready, f_valid, f_pop, f_push;
  logic [8:0] f_data;
  assign f_push = rx_done_r && !busy_r && f_in_ready;
  sync_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_in   (clk_sys_in),
    .rst_n_in     (rst_n_in),
    .in_valid_in  (f_push),
    .in_ready_out (f_in_ready),
    .in_data_in   ({rx_err_r, rx_sh_r}),
    .out_valid_out(f_valid),
    .out_ready_in (f_pop),
    .out_data_out (f_data)
  );
  // ==========================================================
  // Parser
  typedef enum logic [9:0] {
    P_IDLE = 10'b0000000001, P_BODY = 10'b0000000010,
    P_LEN  = 10'b0000000100, P_DATA = 10'b0000001000,
    P_CRCH = 10'b0000010000, P_CRCL = 10'b0000100000,
    P_ETX  = 10'b0001000000, P_EVAL = 10'b0010000000,
    P_PROC = 10'b0100000000, P_RESP = 10'b1000000000
  } pstate_t;
  typedef enum logic [6:0] {
    T_IDLE = 7'b0000001, T_STX = 7'b0000010, T_LEN = 7'b0000100,
    T_DATA = 7'b0001000, T_CRCH = 7'b0010000, T_CRCL = 7'b0100000,
    T_ETX = 7'b1000000
  } tstate_t;
  pstate_t     ps_r;
  tstate_t     ts_r;
  logic        safe_r, load_r, alarm_r, resp_go, alarm_go, query_r;
  logic [6:0]  own_r, addr_r, arg_r;
  logic [1:0]  addr_cnt_r, arg_cnt_r;
  logic        addr_ph_r, pt_r;
  logic [2:0]  body_r, fdig_r, ffrac_r;
  logic [31:0] text_r;
  logic [7:0]  dcnt_r, crch_r;
  logic [15:0] rcrc_r;
  logic [7:0]  b, ch;
  logic        berr, is_dig, is_ctl, feed, addressed;
  cmd_kind_t   kind;
  assign b    = f_data[7:0];
  assign berr = f_data[8];
  assign is_ctl = (b <= CH_SP) || (b >= CH_DEL);
  assign ch   = (b >= CH_LA && b <= CH_LZ) ? (b & CASE_M) : b;
  assign is_dig = (ch >= CH_0) && (ch <= CH_9);
  assign f_pop = f_valid && (ps_r != P_EVAL) && (ps_r != P_PROC) && (ps_r != P_RESP)
                 && !(ps_r == P_IDLE && !safe_r && b != CH_STX && !berr);
  assign feed = f_pop && !berr && ((ps_r == P_BODY && b != CH_CR && !is_ctl) || ps_r == P_DATA);
  assign addressed = (addr_r == own_r);
  always_comb begin
    kind = CMD_OTHER;
    if (body_r == BODY_MAX && text_r == KW_ADDR) kind = CMD_ADDR;
    else if (body_r >= BODY_KW && text_r[31:8] == KW_PROTO) kind = CMD_PROTO;
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ps_r <= P_IDLE; dcnt_r <= '0; crch_r <= '0; rcrc_r <= CRC_INIT;
    end else begin
      case (ps_r)
        P_IDLE: begin
          rcrc_r <= CRC_INIT;
          if (f_valid && !berr) begin
            if (b == CH_STX) ps_r <= P_LEN;
            else if (!safe_r) ps_r <= P_BODY;
          end
        end
        P_BODY: begin
          if (f_valid && berr) ps_r <= P_IDLE;
          else if (f_valid && b == CH_CR) ps_r <= P_EVAL;
        end
        P_LEN: begin
          if (f_valid) begin
            dcnt_r <= b - SAFE_OVH;
            if (berr || b < SAFE_OVH) ps_r <= P_IDLE;
            else ps_r <= (b == SAFE_OVH) ? P_CRCH : P_DATA;
          end
        end
        P_DATA: begin
          if (f_valid) begin
            rcrc_r <= crc_step(rcrc_r, b);
            dcnt_r <= dcnt_r - 1'b1;
            if (berr) ps_r <= P_IDLE;
            else if (dcnt_r == 8'h01) ps_r <= P_CRCH;
          end
        end
        P_CRCH: begin
          if (f_valid) begin
            crch_r <= b;
            ps_r   <= berr ? P_IDLE : P_CRCL;
          end
        end
        P_CRCL: begin
          if (f_valid) begin
            if (berr || {crch_r, b} != rcrc_r) ps_r <= P_IDLE;
            else ps_r <= P_ETX;
          end
        end
        P_ETX: begin
          if (f_valid) ps_r <= (!berr && b == CH_ETX) ? P_EVAL : P_IDLE;
        end
        P_EVAL: begin
          if (!addressed) ps_r <= P_IDLE;
          else if (kind == CMD_OTHER) ps_r <= P_PROC;
          else ps_r <= P_RESP;
        end
        P_PROC: begin
          if (proc_done_in) ps_r <= P_RESP;
        end
        P_RESP: begin
          if (ts_r == T_IDLE) ps_r <= P_IDLE;
        end
        default: ps_r <= P_IDLE;
      endcase
    end
  end
  // ==========================================================
  // Address, keyword and argument tokens
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_ph_r <= 1'b1; addr_r <= ADDR_DEFAULT; addr_cnt_r <= '0;
      body_r <= '0; text_r <= '0; arg_r <= '0; arg_cnt_r <= '0;
      pt_r <= 1'b0; fdig_r <= '0; ffrac_r <= '0;
    end else if (ps_r == P_IDLE) begin
      addr_ph_r <= 1'b1; addr_r <= ADDR_DEFAULT; addr_cnt_r <= '0;
      body_r <= '0; text_r <= '0; arg_r <= '0; arg_cnt_r <= '0;
      pt_r <= 1'b0; fdig_r <= '0; ffrac_r <= '0;
    end else if (feed) begin
      if (addr_ph_r && is_dig && addr_cnt_r != 2'h2) begin
        addr_r     <= 7'(addr_r * TEN) + 7'(ch - CH_0);
        addr_cnt_r <= addr_cnt_r + 1'b1;
      end else begin
        addr_ph_r <= 1'b0;
        if (body_r != BODY_MAX) begin
          text_r[8*(3-body_r[1:0]) +: 8] <= ch;
          body_r <= body_r + 1'b1;
        end
        if (is_dig && body_r >= BODY_KW) begin
          if (arg_cnt_r != 2'h3) arg_cnt_r <= arg_cnt_r + 1'b1;
          if (arg_cnt_r < 2'h2) arg_r <= 7'(arg_r * TEN) + 7'(ch - CH_0);
          if (fdig_r != 3'h7) fdig_r <= fdig_r + 1'b1;
          if (pt_r && ffrac_r != 3'h7) ffrac_r <= ffrac_r + 1'b1;
        end else if (ch == CH_PT && body_r >= BODY_KW) begin
          pt_r  <= 1'b1;
          fdig_r <= pt_r ? 3'h7 : fdig_r;
        end
      end
    end
  end
  // ==========================================================
  // Settings: loaded from storage after reset, rewritten by commands
  logic nv_wr_r;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      load_r <= 1'b1; own_r <= ADDR_DEFAULT; safe_r <= 1'b0;
      nv_wr_r <= 1'b0; query_r <= 1'b0;
    end else begin
      nv_wr_r <= 1'b0;
      if (load_r) begin
        load_r <= 1'b0;
        safe_r <= nv_in.safe;
        own_r  <= (nv_in.addr > ADDR_MAX) ? ADDR_DEFAULT : nv_in.addr;
      end else if (ps_r == P_EVAL && addressed) begin
        query_r <= (kind == CMD_ADDR) && (arg_cnt_r == 2'h0);
        if (kind == CMD_ADDR && arg_cnt_r != 2'h0 && arg_cnt_r != 2'h3) begin
          own_r   <= arg_r;
          nv_wr_r <= 1'b1;
        end
        if (kind == CMD_PROTO && arg_cnt_r != 2'h0) begin
          safe_r  <= (arg_r != 7'h00);
          nv_wr_r <= 1'b1;
        end
      end
    end
  end
  assign nv_out       = '{safe: safe_r, addr: own_r};
  assign nv_write_out = nv_wr_r;
  // ==========================================================
  // Command hand-off to the processor
  cmd_t cmd_r;
  logic cmd_v_r;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_r <= '0; cmd_v_r <= 1'b0;
    end else begin
      cmd_v_r <= (ps_r == P_EVAL) && addressed && (kind == CMD_OTHER);
      if (ps_r == P_EVAL) begin
        cmd_r.kind     <= kind;
        cmd_r.has_arg  <= (arg_cnt_r != 2'h0);
        cmd_r.arg      <= arg_r;
        cmd_r.text     <= text_r;
        cmd_r.phase_ok <= arg_cnt_r inside {2'h1, 2'h2} && arg_r != 7'h00 && arg_r <= PHASE_MAX;
        cmd_r.count_ok <= arg_cnt_r inside {2'h1, 2'h2} && arg_r != 7'h00;
        cmd_r.float_ok <= fdig_r != 3'h0 && fdig_r <= FLT_DIG_MAX && ffrac_r <= FLT_FRAC_MAX;
      end
    end
  end
  assign cmd_valid_out = cmd_v_r;
  assign cmd_out       = cmd_r;
  // ==========================================================
  // Busy window and alarm request
  assign resp_go  = (ps_r == P_RESP) && (ts_r == T_IDLE);
  assign alarm_go = safe_r && alarm_r && (ps_r == P_IDLE) && (ts_r == T_IDLE);
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_r <= 1'b0; alarm_r <= 1'b0;
    end else begin
      if (ps_r == P_EVAL && addressed) busy_r <= 1'b1;
      else if (ts_r == T_STX) busy_r <= 1'b0;
      if (alarm_in && safe_r) alarm_r <= 1'b1;
      else if (alarm_go) alarm_r <= 1'b0;
    end
  end
  assign busy_out = busy_r;
  // ==========================================================
  // Response sequencer
  logic [7:0]  rd_r [RSP_MAX];
  logic [7:0]  rd_n [RSP_MAX];
  logic [2:0]  rn_r, rn_n, di_r;
  logic [15:0] tcrc_r;
  logic [7:0]  tx_byte;
  logic        tx_rdy, tx_go;
  logic [6:0]  a_t, a_o;
  assign a_t = own_r / TEN;
  assign a_o = own_r - 7'(a_t * TEN);
  always_comb begin
    for (int i = 0; i < RSP_MAX; i++) rd_n[i] = CH_0;
    rn_n = '0;
    if (a_t != 7'h00) begin
      rd_n[rn_n] = CH_0 + 8'(a_t);
      rn_n = rn_n + 1'b1;
    end
    rd_n[rn_n] = CH_0 + 8'(a_o);
    rn_n = rn_n + 1'b1;
    rd_n[rn_n] = status_char_in;
    rn_n = rn_n + 1'b1;
    if (query_r && resp_go) begin
      if (a_t != 7'h00) begin
        rd_n[rn_n] = CH_0 + 8'(a_t);
        rn_n = rn_n + 1'b1;
      end
      rd_n[rn_n] = CH_0 + 8'(a_o);
      rn_n = rn_n + 1'b1;
    end
  end
  always_comb begin
    case (ts_r)
      T_STX:   tx_byte = CH_STX;
      T_LEN:   tx_byte = 8'(rn_r) + SAFE_OVH;
      T_DATA:  tx_byte = rd_r[di_r];
      T_CRCH:  tx_byte = tcrc_r[15:8];
      T_CRCL:  tx_byte = tcrc_r[7:0];
      T_ETX:   tx_byte = CH_ETX;
      default: tx_byte = CH_ETX;
    endcase
  end
  assign tx_go = (ts_r != T_IDLE) && tx_rdy;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ts_r <= T_IDLE; rn_r <= '0; di_r <= '0; tcrc_r <= CRC_INIT;
      for (int i = 0; i < RSP_MAX; i++) rd_r[i] <= '0;
    end else if (ts_r == T_IDLE) begin
      if (resp_go || alarm_go) begin
        ts_r <= T_STX;
        rd_r <= rd_n;
        rn_r <= rn_n;
        di_r <= '0;
        tcrc_r <= CRC_INIT;
      end
    end else if (tx_go) begin
      case (ts_r)
        T_STX: ts_r <= safe_r ? T_LEN : T_DATA;
        T_LEN: ts_r <= T_DATA;
        T_DATA: begin
          tcrc_r <= crc_step(tcrc_r, tx_byte);
          di_r   <= di_r + 1'b1;
          if (di_r == rn_r - 1'b1) ts_r <= safe_r ? T_CRCH : T_ETX;
        end
        T_CRCH: ts_r <= T_CRCL;
        T_CRCL: ts_r <= T_ETX;
        default: ts_r <= T_IDLE;
      endcase
    end
  end
  // ==========================================================
  // Transmitter
  logic [9:0]    tx_sh_r;
  logic [3:0]    tx_bits_r;
  logic [CW-1:0] tx_cnt_r;
  assign tx_rdy = (tx_bits_r == 4'h0);
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_sh_r <= '1; tx_bits_r <= '0; tx_cnt_r <= '0;
    end else if (tx_go) begin
      tx_sh_r   <= {1'b1, tx_byte, 1'b0};
      tx_bits_r <= 4'(FRAME_BITS);
      tx_cnt_r  <= BIT_LAST;
    end else if (!tx_rdy) begin
      if (tx_cnt_r != '0) tx_cnt_r <= tx_cnt_r - 1'b1;
      else begin
        tx_cnt_r  <= BIT_LAST;
        tx_sh_r   <= {1'b1, tx_sh_r[9:1]};
        tx_bits_r <= tx_bits_r - 1'b1;
      end
    end
  end
  assign tx_pin_out = tx_rdy ? 1'b1 : tx_sh_r[0];
  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  busy_drop_a: assert property (busy_r |-> !f_push) else $error("byte taken while busy");
  addr_range_a: assert property (!load_r |-> own_r <= ADDR_MAX) else $error("address above 99");
  unaddr_quiet_a: assert property (ps_r == P_EVAL && !addressed |=> ps_r == P_IDLE [*2])
    else $error("unaddressed command not dropped");
  basic_solicit_a: assert property (!safe_r && $rose(ts_r == T_STX) |-> $past(ps_r == P_RESP))
    else $error("unsolicited basic packet");
  proto_frame_a: assert property (ts_r == T_STX && tx_go |=> (ts_r == T_LEN) == $past(safe_r))
    else $error("response framing mismatch");
  crc_reject_a: assert property (ps_r == P_CRCL && f_valid && {crch_r, b} != rcrc_r |=> ps_r == P_IDLE)
    else $error("bad crc accepted");
  ferr_abort_a: assert property (ps_r == P_BODY && f_valid && berr |=> ps_r == P_IDLE)
    else $error("framing error kept command");
  upper_a: assert property (feed && ps_r == P_BODY |-> !(ch inside {[CH_LA:CH_LZ]}) && !is_ctl)
    else $error("basic text not normalised");
  start_bit_a: assert property (tx_go |=> !tx_pin_out [*8]) else $error("start bit missing");
  default_addr_a: assert property (ps_r == P_EVAL && addr_cnt_r == 2'h0 |-> addr_r == ADDR_DEFAULT)
    else $error("missing prefix not address 0");
  basic_cmd_c: cover property (!safe_r && ps_r == P_BODY ##1 ps_r == P_EVAL);
  safe_cmd_c: cover property (ps_r == P_ETX ##1 ps_r == P_EVAL);
  addr_set_c: cover property (nv_wr_r && $changed(own_r));
  alarm_c: cover property (alarm_go);
endmodule // pump_serial_command_framer
`default_nettype wire

// ### verif/host_uart_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Host end of the serial link: sends frames, collects replies
module host_uart_model #(
  parameter int BIT_CYCLES = 16
) (
  input  wire logic clk_sys_in, // System clock
  output logic      line_out,   // To device serial in
  input  wire logic line_in     // From device serial out
);
  logic [7:0] got_q[$];
  initial line_out = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out = f[i];
      repeat (BIT_CYCLES) @(negedge clk_sys_in);
    end
  endtask
  // Stop bit forced low, then one idle bit so the receiver can find the next start
  task automatic send_bad(input logic [7:0] b);
    logic [10:0] f;
    f = {2'b10, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_out = f[i];
      repeat (BIT_CYCLES) @(negedge clk_sys_in);
    end
  endtask
  // A bad stop bit is queued as 8'hff so the bench sees it as a wrong byte
  always begin : rx_frame
    logic [7:0] d;
    @(negedge line_in);
    repeat (BIT_CYCLES / 2) @(posedge clk_sys_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge clk_sys_in);
      d[i] = line_in;
    end
    repeat (BIT_CYCLES) @(posedge clk_sys_in);
    got_q.push_back((line_in === 1'b1) ? d : 8'hff);
  end
endmodule // host_uart_model
`default_nettype wire

// ### verif/pump_serial_command_framer_bench.sv
`timescale 1ns/10ps
`default_nettype none
module pump_serial_command_framer_bench;
  import pump_framer_pkg::*;
  localparam int BC = 16;
  typedef logic [7:0] byte_q_t[$];
  logic       clk_sys_in, rst_n_in, rx_line, tx_line, nv_write, alarm, cmd_valid, proc_done, busy;
  logic [7:0] st;
  nv_t        nv_i, nv_o;
  cmd_t       cmd;
  int         errors, checks, a, p, writes, pulses;
  byte_q_t    pkt;
  pump_serial_command_framer #(.BIT_CYCLES(BC)) i_pump_serial_command_framer (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .rx_pin_in(rx_line), .tx_pin_out(tx_line),
    .nv_in(nv_i), .nv_out(nv_o), .nv_write_out(nv_write), .status_char_in(st), .alarm_in(alarm),
    .cmd_valid_out(cmd_valid), .cmd_out(cmd), .proc_done_in(proc_done), .busy_out(busy));
  host_uart_model #(.BIT_CYCLES(BC)) i_host_uart_model (
    .clk_sys_in(clk_sys_in), .line_out(rx_line), .line_in(tx_line));
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    writes <= writes + ((nv_write === 1'b1) ? 1 : 0);
    pulses <= pulses + ((cmd_valid === 1'b1) ? 1 : 0);
  end
  // ==========================================================
  // Shared tasks and expectations
  task automatic check(input bit ok, input string msg);
    checks++;
    if (!ok) begin
      errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic send_cmd(input string s);
    for (int i = 0; i < s.len(); i++) i_host_uart_model.send_byte(s[i]);
  endtask
  task automatic send_q(input byte_q_t q);
    foreach (q[i]) i_host_uart_model.send_byte(q[i]);
  endtask
  function automatic byte_q_t digs(input int v);
    byte_q_t r;
    if (v >= 10) r.push_back(CH_0 + 8'(v / 10));
    r.push_back(CH_0 + 8'(v % 10));
    return r;
  endfunction
  function automatic byte_q_t rsp(input int v, input logic [7:0] s, input bit q);
    byte_q_t r;
    r = {CH_STX, digs(v), s};
    if (q) r = {r, digs(v)};
    r.push_back(CH_ETX);
    return r;
  endfunction
  // Safe framing: start, length, data, CRC high and low over the data, end
  function automatic byte_q_t spkt(input byte_q_t d);
    logic [15:0] c;
    byte_q_t     r;
    c = CRC_INIT;
    foreach (d[i]) begin
      c = c ^ {d[i], 8'h00};
      for (int k = 0; k < 8; k++) c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    r = {CH_STX, 8'(d.size()) + SAFE_OVH, d, c[15:8], c[7:0], CH_ETX};
    return r;
  endfunction
  function automatic byte_q_t proto_cmd(input int v, input logic [7:0] arg);
    byte_q_t r;
    r = digs(v);
    r = {r, KW_PROTO[23:16], KW_PROTO[15:8], KW_PROTO[7:0], arg};
    return r;
  endfunction
  task automatic expect_rsp(input byte_q_t e);
    int n;
    n = 0;
    while (i_host_uart_model.got_q.size() < e.size() && n < 9000) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n >= 9000) begin
      errors++;
      $display("mismatch at %0t: response timeout", $time);
      tally_and_finish();
    end else begin
      foreach (e[i]) check(i_host_uart_model.got_q.pop_front() === e[i], "response byte");
    end
  endtask
  // ==========================================================
  // Main sequence; the host waits for each reply before sending again, except the digit sent while the command is held busy
  initial begin
    errors = 0; checks = 0; writes = 0; pulses = 0;
    void'($urandom(32'hd336));
    rst_n_in = 1'b0; nv_i = '0; st = 8'h53; alarm = 1'b0; proc_done = 1'b0;
    repeat (5) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    send_cmd(" *a d\tr\r");
    expect_rsp(rsp(0, st, 1));
    $display("test query done");
    a = 10 + $urandom % 90;
    send_cmd($sformatf("*ADR%0d\r", a));
    expect_rsp(rsp(a, st, 0));
    check(nv_o.addr === 7'(a) && nv_o.safe === 1'b0 && writes == 1, "address store");
    $display("test address set done");
    send_cmd("RAT\r");
    repeat (2000) @(negedge clk_sys_in);
    check(i_host_uart_model.got_q.size() == 0 && pulses == 0, "unaddressed answered");
    $display("test foreign address done");
    p = 1 + $urandom % 60;
    send_cmd($sformatf("%0drat%0d\r", a, p));
    for (int n = 0; n < 500 && pulses == 0; n++) @(negedge clk_sys_in);
    check(pulses == 1 && cmd.kind === CMD_OTHER && cmd.text[31:8] === 24'h524154, "command fields");
    check(cmd.has_arg === 1'b1 && cmd.arg === 7'(p) && cmd.phase_ok === (p <= PHASE_MAX)
          && cmd.count_ok === 1'b1 && cmd.float_ok === 1'b1, "argument flags");
    if (pulses == 0) tally_and_finish();
    check(busy === 1'b1, "busy not held");
    send_cmd("1");
    proc_done = 1'b1;
    @(negedge clk_sys_in);
    proc_done = 1'b0;
    expect_rsp(rsp(a, st, 0));
    check(busy === 1'b0 && pulses == 1, "busy after reply");
    $display("test held off input done");
    st = 8'h41 + 8'($urandom % 26);
    send_cmd($sformatf("%0d*ADR\r", a));
    expect_rsp(rsp(a, st, 1));
    $display("test addressed query done");
    send_q(spkt(proto_cmd(a, CH_0 + 8'h01)));
    pkt = {digs(a), st};
    expect_rsp(spkt(pkt));
    check(nv_o.safe === 1'b1 && writes == 2, "protocol store");
    send_cmd($sformatf("%0d*ADR\r", a));
    pkt = spkt(proto_cmd(a, CH_0));
    pkt[pkt.size() - 2] = ~pkt[pkt.size() - 2];
    send_q(pkt);
    repeat (400) @(negedge clk_sys_in);
    check(i_host_uart_model.got_q.size() == 0 && nv_o.safe === 1'b1, "bad packet answered");
    send_q(spkt(proto_cmd(a, CH_0)));
    expect_rsp(rsp(a, st, 0));
    check(nv_o.safe === 1'b0 && writes == 3, "protocol restore");
    $display("test safe protocol done");
    alarm = 1'b1;
    @(negedge clk_sys_in);
    alarm = 1'b0;
    send_q(digs(a));
    i_host_uart_model.send_bad(CH_0);
    send_cmd("\r");
    repeat (400) @(negedge clk_sys_in);
    check(i_host_uart_model.got_q.size() == 0 && pulses == 1, "framing error kept command");
    $display("test framing error done");
    nv_i = '{safe: 1'b1, addr: 7'(a)};
    rst_n_in = 1'b0;
    repeat (5) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    check(nv_o === nv_i, "settings not reloaded");
    alarm = 1'b1;
    @(negedge clk_sys_in);
    alarm = 1'b0;
    pkt = {digs(a), st};
    expect_rsp(spkt(pkt));
    $display("test power-up protocol done");
    tally_and_finish();
  end
endmodule // pump_serial_command_framer_bench
`default_nettype wire
